/* logic/ssb_map.svh */
// register map, field positions and reset values of the spi slave
// Function
// - select, clock, data-in are always inputs
// - selected slave drives data-out if pin output
// - deselected: no receive, data-out released
// - select high resets engine and bit counter
// - select rise mid-byte discards both bytes
// - normal mode idles while select high
// - shift from first clock; flag on byte
// - normal write during transfer ignored, collision flag
// - buffer enable bit turns on buffered operation
// - wait-receive zero: writes to buffer, dummy first
// - write into full buffer is lost
// - empty flag clears on write, sets on move
// - receive flag one cycle after empty flag
// - transfer flag after receive, all sent
// - wait-receive one: first deselected write to shifter
// - flags behave same in both sub-modes
// - mode field picks phase and polarity
// - clock event output holds idle level
// - no event inputs
// - each source sets its own flag
// - request while enable and flag both set
// - mode encoding: polarity high bit, phase low
// - bit order: msb first when clear
`ifndef SSB_MAP_SVH
`define SSB_MAP_SVH
// register indices, byte address is index times four
`define SSB_IDX_CTRLA   3'h0
`define SSB_IDX_CTL2    3'h1
`define SSB_IDX_IEN     3'h2
`define SSB_IDX_FLAGS   3'h3
`define SSB_IDX_DATA    3'h4
`define SSB_CTRL_RST    8'h00
// control a
`define SSB_LSBF   6
`define SSB_MASTER 5
`define SSB_ENABLE 0
// control b
`define SSB_BUF_ON   7
`define SSB_BUF_WAIT 6
`define SSB_CPOL   1
`define SSB_CPHA   0
// interrupt enables and flags, buffered view
`define SSB_F_RXDN  7
`define SSB_F_TXDN  6
`define SSB_F_EMPTY 5
`define SSB_F_SFALL 4
`define SSB_IE  0
// flags, normal view
`define SSB_IF    7
`define SSB_F_COLL 6
`define SSB_BITS_FULL 4'h8
`define SSB_BITS_LAST 4'h7
`endif

/* logic/ssb_pkg.sv */
// types shared by the spi slave design files
package ssb_pkg;
	typedef logic [7:0]  ssb_byte_t;
	typedef logic [31:0] ssb_word_t;
	typedef enum logic [1:0] {
		SSB_IDLE  = 2'b00,
		SSB_SHIFT = 2'b01,
		SSB_DONE  = 2'b11
	} ssb_state_e;
endpackage : ssb_pkg

/* logic/ssb_sync.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module ssb_sync #(
	parameter int                WIDTH   = 3,
	parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
	// system
	input  wire logic             mclk,
	input  wire logic             reset,
	// pins and filtered levels
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// a level only moves once the second and third stages agree
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			level_reg <= RST_VAL;
		else
			level_reg <= (s2_reg & s3_reg) | (level_reg & (s2_reg ^ s3_reg));
	end

	assign level = level_reg;
endmodule : ssb_sync

/* logic/ssb_spi_slave.sv */
// spi slave with normal and buffered transmit modes, avalon-mm registers
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ssb_map.svh"
module ssb_spi_slave (
	// system
	input  wire logic              mclk,
	input  wire logic              reset,
	// avalon-mm slave
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire ssb_pkg::ssb_word_t avs_writedata,
	output ssb_pkg::ssb_word_t     avs_readdata,
	output logic                   avs_waitrequest,
	// spi pins
	input  wire logic              ss_n_pin,
	input  wire logic              sck_pin,
	input  wire logic              mosi_pin,
	input  wire logic              miso_dir_out,
	output logic                   miso_out,
	output logic                   miso_oe,
	// event and interrupt
	output logic                   sck_event,
	output logic                   irq
);
	import ssb_pkg::*;

	// ==================================================================
	// declarations
	ssb_byte_t  ctrla_reg, ctl2_reg, ien_reg;
	ssb_byte_t  shreg_reg, txbuf_reg, rx_data_reg;
	ssb_word_t  rdata_reg;
	ssb_state_e state_reg;
	logic [3:0] bits_reg;
	logic [2:0] pin_lvl;
	logic       wait_reg, ss_d_reg, sck_d_reg, latch_reg, busy_reg;
	logic       empty_reg, rxdn_reg, txdn_reg, sfall_reg, if_reg, wcol_reg;
	logic       pend_reg, sh_loaded_reg, p1_reg, p2_reg, empty_at_done_reg;
	logic       miso_reg, oe_reg, sck_ev_reg, irq_reg;
	logic       ss_hi, sck_lvl, mosi_lvl, ss_rise, ss_fall, sck_chg;
	logic       cpol, cpha, lsbf, buf_on, buf_wait, active;
	logic       sample_ev, setup_ev, setup_shift, byte_end, done;
	logic       acc, wr_data, wr_flags, buf_wr, move, load_buf;
	ssb_byte_t  clr, flags_view;

	function automatic logic reg_hit(input logic [4:0] a, input logic [2:0] idx);
		reg_hit = (a[4:2] == idx) && (a[1:0] == 2'b00);
	endfunction : reg_hit

	function automatic ssb_byte_t shift_in(input ssb_byte_t s, input logic b,
			input logic lsb_first);
		shift_in = lsb_first ? {b, s[7:1]} : {s[6:0], b};
	endfunction : shift_in

	// ==================================================================
	// pin sampling: select, clock and data-in pins are only ever read here
	ssb_sync #(.WIDTH(3), .RST_VAL(3'h1)) u_sync (
		.mclk  (mclk),
		.reset (reset),
		.din   ({mosi_pin, sck_pin, ss_n_pin}),
		.level (pin_lvl)
	);
	assign ss_hi    = pin_lvl[0];
	assign sck_lvl  = pin_lvl[1];
	assign mosi_lvl = pin_lvl[2];

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ss_d_reg  <= 1'b1;
			sck_d_reg <= 1'b0;
		end else begin
			ss_d_reg  <= ss_hi;
			sck_d_reg <= sck_lvl;
		end
	end

	// edges are only trustworthy if each clock phase spans over two cycles
	assign ss_rise = ss_hi & ~ss_d_reg;
	assign ss_fall = ~ss_hi & ss_d_reg;
	assign sck_chg = sck_lvl ^ sck_d_reg;

	assign cpol     = ctl2_reg[`SSB_CPOL];
	assign cpha     = ctl2_reg[`SSB_CPHA];
	assign lsbf     = ctrla_reg[`SSB_LSBF];
	assign buf_on   = ctl2_reg[`SSB_BUF_ON];
	assign buf_wait = ctl2_reg[`SSB_BUF_WAIT];
	assign active = ctrla_reg[`SSB_ENABLE] & ~ctrla_reg[`SSB_MASTER] & ~ss_hi;

	// leading edge leaves the idle level; phase picks which edge samples
	assign sample_ev = active & sck_chg & ((sck_d_reg == cpol) ^ cpha);
	assign setup_ev  = active & sck_chg & ((sck_d_reg != cpol) ^ cpha);
	assign setup_shift = setup_ev & (~cpha | (bits_reg != 4'h0));
	assign byte_end = cpha ? (sample_ev & (bits_reg == `SSB_BITS_LAST))
	                       : (setup_ev & (bits_reg == `SSB_BITS_FULL));
	assign done = (state_reg == SSB_DONE);

	// ==================================================================
	// avalon-mm slave: one wait cycle, then the request is taken
	assign acc      = (avs_read | avs_write) & ~wait_reg;
	assign wr_data  = acc & avs_write & reg_hit(avs_address, `SSB_IDX_DATA);
	assign wr_flags = acc & avs_write & reg_hit(avs_address, `SSB_IDX_FLAGS);
	assign clr      = wr_flags ? avs_writedata[7:0] : 8'h00;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			wait_reg <= 1'b1;
		else if (!wait_reg)
			wait_reg <= 1'b1;
		else if (avs_read || avs_write)
			wait_reg <= 1'b0;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrla_reg   <= `SSB_CTRL_RST;
			ctl2_reg    <= `SSB_CTRL_RST;
			ien_reg     <= `SSB_CTRL_RST;
		end else if (acc && avs_write) begin
			if (reg_hit(avs_address, `SSB_IDX_CTRLA))
				ctrla_reg <= avs_writedata[7:0];
			if (reg_hit(avs_address, `SSB_IDX_CTL2))
				ctl2_reg <= avs_writedata[7:0];
			if (reg_hit(avs_address, `SSB_IDX_IEN))
				ien_reg <= avs_writedata[7:0];
		end
	end

	always_comb begin
		flags_view = 8'h00;
		if (buf_on) begin
			flags_view[`SSB_F_RXDN]  = rxdn_reg;
			flags_view[`SSB_F_TXDN]  = txdn_reg;
			flags_view[`SSB_F_EMPTY] = empty_reg;
			flags_view[`SSB_F_SFALL] = sfall_reg;
		end else begin
			flags_view[`SSB_IF]     = if_reg;
			flags_view[`SSB_F_COLL] = wcol_reg;
		end
	end

	// unmapped or misaligned addresses read as zero
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			rdata_reg <= 32'h0000_0000;
		else if (wait_reg && avs_read) begin
			rdata_reg <= 32'h0000_0000;
			if (avs_address[1:0] == 2'b00) begin
				case (avs_address[4:2])
					`SSB_IDX_CTRLA:   rdata_reg[7:0] <= ctrla_reg;
					`SSB_IDX_CTL2:    rdata_reg[7:0] <= ctl2_reg;
					`SSB_IDX_IEN:     rdata_reg[7:0] <= ien_reg;
					`SSB_IDX_FLAGS:   rdata_reg[7:0] <= flags_view;
					`SSB_IDX_DATA:    rdata_reg[7:0] <= rx_data_reg;
					default:          rdata_reg[7:0] <= 8'h00;
				endcase
			end
		end
	end

	// ==================================================================
	// slave engine; losing select drops everything in flight
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_reg <= SSB_IDLE;
			bits_reg  <= 4'h0;
		end else if (!active) begin
			state_reg <= SSB_IDLE;
			bits_reg  <= 4'h0;
		end else begin
			case (state_reg)
				SSB_IDLE:  state_reg <= SSB_SHIFT;
				SSB_SHIFT: if (byte_end) state_reg <= SSB_DONE;
				SSB_DONE:  state_reg <= SSB_SHIFT;
				default:   state_reg <= SSB_IDLE;
			endcase
			if (byte_end)
				bits_reg <= 4'h0;
			else if (sample_ev)
				bits_reg <= bits_reg + 4'h1;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			latch_reg <= 1'b0;
			busy_reg  <= 1'b0;
		end else begin
			if (sample_ev)
				latch_reg <= mosi_lvl;
			if (!active || byte_end)
				busy_reg <= 1'b0;
			else if (sample_ev || setup_ev)
				busy_reg <= 1'b1;
		end
	end

	// ==================================================================
	// shift register and transmit buffer
	assign buf_wr   = wr_data & buf_on & empty_reg;
	assign move     = done & buf_on & ~empty_reg;
	assign load_buf = move | pend_reg;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			shreg_reg <= 8'h00;
		else if (setup_shift)
			shreg_reg <= shift_in(shreg_reg, latch_reg, lsbf);
		else if (cpha && byte_end)
			shreg_reg <= shift_in(shreg_reg, mosi_lvl, lsbf);
		else if (load_buf)
			shreg_reg <= txbuf_reg;
		else if (wr_data && !buf_on && !busy_reg)
			shreg_reg <= avs_writedata[7:0];
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			txbuf_reg <= 8'h00;
		else if (buf_wr)
			txbuf_reg <= avs_writedata[7:0];
	end

	// wait-receive: first deselected write hops on to the shifter next cycle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pend_reg      <= 1'b0;
			sh_loaded_reg <= 1'b0;
		end else begin
			pend_reg <= buf_wr & buf_wait & ss_hi & ~sh_loaded_reg;
			if (pend_reg)
				sh_loaded_reg <= 1'b1;
			else if (done && empty_reg)
				sh_loaded_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			rx_data_reg <= 8'h00;
		else if (done)
			rx_data_reg <= shreg_reg;
	end

	// ==================================================================
	// flags; a hardware set always beats a software clear
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			empty_reg <= 1'b1;
		else if (load_buf)
			empty_reg <= 1'b1;
		else if (buf_wr)
			empty_reg <= 1'b0;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			p1_reg            <= 1'b0;
			p2_reg            <= 1'b0;
			empty_at_done_reg <= 1'b0;
		end else begin
			p1_reg            <= done & buf_on;
			p2_reg            <= p1_reg;
			// held until the next byte so the check two cycles on still sees it
			if (done)
				empty_at_done_reg <= empty_reg;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rxdn_reg  <= 1'b0;
			txdn_reg  <= 1'b0;
			sfall_reg <= 1'b0;
		end else begin
			if (p1_reg)
				rxdn_reg <= 1'b1;
			else if (buf_on && clr[`SSB_F_RXDN])
				rxdn_reg <= 1'b0;
			if (p2_reg && empty_at_done_reg && empty_reg)
				txdn_reg <= 1'b1;
			else if (buf_on && clr[`SSB_F_TXDN])
				txdn_reg <= 1'b0;
			if (ss_fall && buf_on && ctrla_reg[`SSB_ENABLE] && !ctrla_reg[`SSB_MASTER])
				sfall_reg <= 1'b1;
			else if (buf_on && clr[`SSB_F_SFALL])
				sfall_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			if_reg   <= 1'b0;
			wcol_reg <= 1'b0;
		end else begin
			if (done && !buf_on)
				if_reg <= 1'b1;
			else if (!buf_on && clr[`SSB_IF])
				if_reg <= 1'b0;
			if (wr_data && !buf_on && busy_reg)
				wcol_reg <= 1'b1;
			else if (!buf_on && clr[`SSB_F_COLL])
				wcol_reg <= 1'b0;
		end
	end

	// ==================================================================
	// pin, event and interrupt outputs; no event inputs exist
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			miso_reg   <= 1'b0;
			oe_reg     <= 1'b0;
			sck_ev_reg <= 1'b0;
			irq_reg    <= 1'b0;
		end else begin
			miso_reg <= lsbf ? shreg_reg[0] : shreg_reg[7];
			oe_reg   <= active & miso_dir_out;
			// no master clock here, so the event only shows the idle level
			sck_ev_reg <= cpol;
			irq_reg <= buf_on ? |({rxdn_reg, txdn_reg, empty_reg, sfall_reg}
			                     & ien_reg[`SSB_F_RXDN:`SSB_F_SFALL])
			                  : (ien_reg[`SSB_IE] & if_reg);
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign miso_out        = miso_reg;
	assign miso_oe         = oe_reg;
	assign sck_event       = sck_ev_reg;
	assign irq             = irq_reg;

	// ==================================================================
	// assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_desel_oe_off: assert property (ss_hi |=> !miso_oe)
		else $error("data-out driven while deselected");
	a_rise_resets: assert property (ss_rise |=> bits_reg == 4'h0 ##0 state_reg == SSB_IDLE)
		else $error("select rise left engine running");
	a_idle_no_shift: assert property (ss_hi && ss_d_reg |-> $stable(shreg_reg)
			|| $past(load_buf || wr_data))
		else $error("shift register moved while deselected");
	a_done_sets_if: assert property (done && !buf_on |=> if_reg)
		else $error("byte done without flag");
	a_wcol_set: assert property (wr_data && !buf_on && busy_reg |=> wcol_reg
			&& ($stable(shreg_reg) || $past(setup_shift || (cpha && byte_end))))
		else $error("collision not flagged");
	a_full_lost: assert property (wr_data && buf_on && !empty_reg && !load_buf
			|=> $stable(txbuf_reg))
		else $error("full transmit buffer overwritten");
	a_rx_after_empty: assert property ($rose(empty_reg) && !$past(pend_reg) |=> rxdn_reg)
		else $error("receive flag late");
	a_tx_after_rx: assert property (done && buf_on && empty_reg && !buf_wr
			##1 !buf_wr ##1 !buf_wr |=> txdn_reg)
		else $error("transfer flag missing");
	a_direct_copy: assert property (buf_wr && buf_wait && ss_hi && !sh_loaded_reg
			|=> ##1 shreg_reg == $past(avs_writedata[7:0], 2))
		else $error("first write not copied to shifter");
	a_irq_follows: assert property (!buf_on && ien_reg[`SSB_IE] && if_reg
			&& $stable(buf_on) |=> irq)
		else $error("interrupt not raised");
	a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
			|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing off");

	c_normal_byte: cover property (done && !buf_on);
	c_collision: cover property (wr_data && !buf_on && busy_reg);
	c_buffer_lost: cover property (wr_data && buf_on && !empty_reg);
	c_mid_byte_abort: cover property (ss_rise && bits_reg != 4'h0);
endmodule : ssb_spi_slave

/* verification/ssb_spi_master_model.sv */
// spi master model: drives select, clock and data-in, samples data-out
`timescale 1ns/1ps
module ssb_spi_master_model #(
	parameter int HALF_NS = 80
) (
	// pins toward the slave
	output logic      ss_n,
	output logic      sck,
	output logic      mosi,
	// data-out as seen on the wire
	input  wire logic miso
);
	initial begin
		ss_n = 1'b1;
		sck  = 1'b0;
		mosi = 1'b0;
	end

	// ==========================================================
	// one frame; nbits below eight raises select mid-byte
	task automatic xfer(input logic [1:0] mode, input logic lsb, input logic [7:0] tx,
			input int nbits, output logic [7:0] rx);
		int idx;
		rx = 8'h00;
		#3;
		// clock parks at the idle level while deselected
		sck = mode[1];
		#HALF_NS;
		ss_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			idx = lsb ? i : 7 - i;
			if (!mode[0]) mosi = tx[idx];
			// each phase lasts eight slave cycles
			#HALF_NS;
			sck = ~mode[1];
			if (mode[0]) mosi = tx[idx];
			else rx[idx] = miso;
			#HALF_NS;
			sck = mode[1];
			if (mode[0]) rx[idx] = miso;
		end
		#HALF_NS;
		ss_n = 1'b1;
		// released data line must not keep a lucky value
		mosi = ~mosi;
		#HALF_NS;
	endtask : xfer
endmodule : ssb_spi_master_model

/* verification/ssb_spi_slave_tb_top.sv */
// self-checking bench for the spi slave: register bus, normal and buffered frames
`timescale 1ns/1ps
`include "ssb_map.svh"
module ssb_spi_slave_tb_top;
	import ssb_pkg::*;
	localparam logic [4:0] A_CTLA = {`SSB_IDX_CTRLA, 2'b00};
	localparam logic [4:0] A_CTLB = {`SSB_IDX_CTL2, 2'b00};
	localparam logic [4:0] A_IEN  = {`SSB_IDX_IEN, 2'b00};
	localparam logic [4:0] A_FLG  = {`SSB_IDX_FLAGS, 2'b00};
	localparam logic [4:0] A_DAT  = {`SSB_IDX_DATA, 2'b00};
	logic       mclk, reset, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	ssb_word_t  avs_writedata, avs_readdata, q;
	logic       ss_n, sck, mosi, miso_dir_out, miso_out, miso_oe, sck_event, irq;
	logic       miso_hold = 1'b0;
	wire logic  miso_line;
	logic [7:0] rx;
	int         n_mismatch = 0;
	int         cmp_count  = 0;

	// released wire shows the inverse of the last driven bit
	always @(miso_oe or miso_out)
		if (miso_oe === 1'b1) miso_hold = miso_out;
	assign miso_line = (miso_oe === 1'b1) ? miso_out : ~miso_hold;

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	ssb_spi_slave i_ssb_spi_slave (
		.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ss_n_pin(ss_n), .sck_pin(sck), .mosi_pin(mosi),
		.miso_dir_out(miso_dir_out), .miso_out(miso_out), .miso_oe(miso_oe),
		.sck_event(sck_event), .irq(irq)
	);
	ssb_spi_master_model i_ssb_spi_master_model (
		.ss_n(ss_n), .sck(sck), .mosi(mosi), .miso(miso_line)
	);

	// ==========================================================
	// reporting and comparison
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check8

	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask : check1

	// ==========================================================
	// avalon-mm master: request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address   <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write     <= wr;
		avs_read      <= ~wr;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask : bus

	// ==========================================================
	// scenarios
	task automatic t_reset;
		check1(miso_oe, 1'b0);
		check1(sck_event, 1'b0);
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, 5'(i * 4), 8'h00);
			check8(q[7:0], `SSB_CTRL_RST);
		end
		// unmapped place: write dropped, read gives zero
		bus(1'b1, 5'h14, 8'hff);
		bus(1'b0, 5'h14, 8'h00);
		check8(q[7:0], 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_normal;
		logic [7:0] tx;
		for (int m = 0; m < 8; m++) begin
			tx = 8'h96 ^ 8'(m * 37);
			bus(1'b1, A_CTLA, m[2] ? 8'h41 : 8'h01);
			bus(1'b1, A_CTLB, {6'h00, m[1:0]});
			bus(1'b1, A_DAT, tx);
			check1(sck_event, m[1]);
			i_ssb_spi_master_model.xfer(m[1:0], m[2], ~tx, 8, rx);
			check8(rx, tx);
			bus(1'b0, A_FLG, 8'h00);
			check1(q[`SSB_IF], 1'b1);
			bus(1'b0, A_DAT, 8'h00);
			check8(q[7:0], ~tx);
			bus(1'b1, A_FLG, 8'hc0);
		end
		$display("test normal done");
	endtask : t_normal

	task automatic t_collision;
		bus(1'b1, A_CTLA, 8'h01);
		bus(1'b1, A_CTLB, 8'h00);
		bus(1'b1, A_IEN, 8'h01);
		bus(1'b1, A_DAT, 8'h3c);
		fork
			i_ssb_spi_master_model.xfer(2'b00, 1'b0, 8'h00, 8, rx);
			begin
				#500;
				check1(miso_oe, 1'b1);
				bus(1'b1, A_DAT, 8'hc3);
			end
		join
		check8(rx, 8'h3c);
		bus(1'b0, A_FLG, 8'h00);
		check1(q[`SSB_F_COLL], 1'b1);
		check1(irq, 1'b1);
		bus(1'b1, A_FLG, 8'hc0);
		bus(1'b0, A_FLG, 8'h00);
		check1(irq, 1'b0);
		bus(1'b1, A_IEN, 8'h00);
		$display("test collision done");
	endtask : t_collision

	task automatic t_abort;
		bus(1'b1, A_CTLB, 8'h03);
		bus(1'b1, A_DAT, 8'ha7);
		i_ssb_spi_master_model.xfer(2'b11, 1'b0, 8'hff, 4, rx);
		check1(miso_oe, 1'b0);
		bus(1'b0, A_FLG, 8'h00);
		check1(q[`SSB_IF], 1'b0);
		bus(1'b1, A_DAT, 8'h5e);
		i_ssb_spi_master_model.xfer(2'b11, 1'b0, 8'h69, 8, rx);
		check8(rx, 8'h5e);
		bus(1'b0, A_DAT, 8'h00);
		check8(q[7:0], 8'h69);
		bus(1'b1, A_FLG, 8'hc0);
		// data-out pin left as input: never driven, still receives
		@(posedge mclk) miso_dir_out <= 1'b0;
		bus(1'b1, A_CTLB, 8'h00);
		fork
			i_ssb_spi_master_model.xfer(2'b00, 1'b0, 8'h2d, 8, rx);
			begin
				#500;
				check1(miso_oe, 1'b0);
			end
		join
		bus(1'b0, A_DAT, 8'h00);
		check8(q[7:0], 8'h2d);
		@(posedge mclk) miso_dir_out <= 1'b1;
		$display("test abort done");
	endtask : t_abort

	task automatic t_buf0;
		bus(1'b1, A_CTLB, 8'h80);
		bus(1'b1, A_IEN, 8'h80);
		bus(1'b1, A_FLG, 8'hf0);
		bus(1'b0, A_FLG, 8'h00);
		check8(q[7:0], 8'h20);
		bus(1'b1, A_DAT, 8'h43);
		bus(1'b0, A_FLG, 8'h00);
		check1(q[`SSB_F_EMPTY], 1'b0);
		bus(1'b1, A_DAT, 8'h45);
		i_ssb_spi_master_model.xfer(2'b00, 1'b0, 8'h81, 8, rx);
		check8(rx, 8'h2d);
		bus(1'b0, A_FLG, 8'h00);
		check8(q[7:0], 8'hb0);
		check1(irq, 1'b1);
		bus(1'b1, A_FLG, 8'hf0);
		bus(1'b0, A_FLG, 8'h00);
		check8(q[7:0], 8'h20);
		check1(irq, 1'b0);
		i_ssb_spi_master_model.xfer(2'b00, 1'b0, 8'h82, 8, rx);
		check8(rx, 8'h43);
		bus(1'b0, A_FLG, 8'h00);
		check8(q[7:0], 8'hf0);
		bus(1'b0, A_DAT, 8'h00);
		check8(q[7:0], 8'h82);
		bus(1'b1, A_IEN, 8'h00);
		$display("test buffered done");
	endtask : t_buf0

	task automatic t_buf1;
		bus(1'b1, A_CTLA, 8'h00);
		bus(1'b1, A_CTLA, 8'h01);
		bus(1'b1, A_CTLB, 8'hc1);
		bus(1'b1, A_FLG, 8'hf0);
		bus(1'b1, A_DAT, 8'h61);
		bus(1'b0, A_FLG, 8'h00);
		check1(q[`SSB_F_EMPTY], 1'b1);
		bus(1'b1, A_DAT, 8'h62);
		bus(1'b1, A_DAT, 8'h65);
		i_ssb_spi_master_model.xfer(2'b01, 1'b0, 8'h91, 8, rx);
		check8(rx, 8'h61);
		bus(1'b0, A_FLG, 8'h00);
		check8(q[7:0], 8'hb0);
		i_ssb_spi_master_model.xfer(2'b01, 1'b0, 8'h92, 8, rx);
		check8(rx, 8'h62);
		bus(1'b0, A_FLG, 8'h00);
		check8(q[7:0], 8'hf0);
		$display("test wait-receive done");
	endtask : t_buf1

	// ==========================================================
	// main sequence and watchdog
	initial begin
		reset         = 1'b1;
		avs_address   = 5'h00;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0000_0000;
		miso_dir_out  = 1'b1;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_normal();
		t_collision();
		t_abort();
		t_buf0();
		t_buf1();
		report_and_stop();
	end

	initial begin
		#100_000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : ssb_spi_slave_tb_top
